//--- include/ddrs_pkg.sv
/*
 * Shared constants and types of the DDR SDRAM device model: pin widths, command
 * codes, mode-register field positions, register offsets and reset values.
 * Assumes nothing of its surroundings; every use is written ddrs_pkg::name.
 */
package ddrs_pkg;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int DQ_W = 32;
	localparam int DM_W = 4;
	localparam int CTL_W = 20;

	// {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_TERM = 3'h6;

	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_DLL_RST_BIT = 8;
	localparam int EMR_DLL_BIT = 0;
	localparam int EMR_SEL_BA_BIT = 0;
	localparam int AP_BIT = 8;
	localparam int PRE_ALL_BIT = 10;

	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] BL_CODE_FULL = 3'h7;
	localparam logic [8:0] BEATS_2 = 9'h002;
	localparam logic [8:0] BEATS_4 = 9'h004;
	localparam logic [8:0] BEATS_8 = 9'h008;
	localparam logic [8:0] BEATS_FULL = 9'h100;

	localparam logic [1:0] READ_LATENCY = 2'h3;
	localparam logic [7:0] DLL_LOCK_CYCLES = 8'hc8;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_EXT_MODE = 8'h0c;
	localparam logic [7:0] OFS_REFRESH_CNT = 8'h10;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'b1;
	localparam int ST_DLL_LOCK_BIT = 0;
	localparam int ST_DLL_WAIT_BIT = 1;
	localparam int ST_PW_LSB = 2;
	localparam int ST_DP_LSB = 4;
	localparam int ST_OPEN_LSB = 8;
	localparam int ST_MODE_WR_BIT = 12;
	localparam int ST_EXT_WR_BIT = 13;

	typedef enum logic [1:0] {
		DP_IDLE = 2'h0,
		DP_RD_WAIT = 2'h1,
		DP_READ = 2'h3,
		DP_WRITE = 2'h2
	} ddrs_dp_e;

	typedef enum logic [1:0] {
		PW_ACTIVE = 2'h0,
		PW_PDOWN = 2'h1,
		PW_SELF = 2'h3
	} ddrs_pw_e;
endpackage

//--- src/ddrs_sync.sv
/*
 * Two-flop synchroniser for a bundle of pins.
 * Assumes each bit is a level that stays put for several clk_sys cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [W-1:0] d, // asynchronous pin levels
	output logic [W-1:0] q // levels in clk_sys domain
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule
`default_nettype wire

//--- src/ddrs_mem.sv
/*
 * Byte-writable storage array with a registered read port.
 * Assumes write and read addresses are stable in the cycle they are used.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrs_mem #(
	parameter int AW = 12,
	parameter int DW = 32,
	parameter int BW = 4
) (
	input wire logic clk_sys, // system clock
	input wire logic wr_en, // write strobe
	input wire logic [AW-1:0] wr_addr, // write word address
	input wire logic [DW-1:0] wr_data, // write data
	input wire logic [BW-1:0] wr_be, // byte enables, high writes the lane
	input wire logic [AW-1:0] rd_addr, // read word address
	output logic [DW-1:0] rd_data // read data, one cycle after address
);
	logic [DW-1:0] store [2**AW];
	logic [DW-1:0] rd_reg;

	always_ff @(posedge clk_sys) begin
		for (int b = 0; b < BW; b++) begin
			if (wr_en && wr_be[b]) begin
				store[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
			end
		end
		rd_reg <= store[rd_addr];
	end

	assign rd_data = rd_reg;
endmodule
`default_nettype wire

//--- src/ddrs_device.sv
/*
 * DDR SDRAM device: command decoder, bank rows, mode registers, DLL lock wait,
 * power-down/self-refresh tracking and the strobe-timed data path, with a
 * Wishbone slave for control and status.
 * Assumes the controller's clock, strobe and data pins are much slower than
 * clk_sys (at least four clk_sys cycles per half period), so edges are found
 * by oversampling after a two-flop synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrs_device #(
	parameter int MEM_ROW_BITS = 2
) (
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic ck_pin, // memory clock from controller
	input wire logic cke_pin, // clock enable
	input wire logic cs_n_pin, // chip select, low active
	input wire logic ras_n_pin, // row strobe, low active
	input wire logic cas_n_pin, // column strobe, low active
	input wire logic we_n_pin, // write enable, low active
	input wire logic [1:0] ba_pin, // bank select
	input wire logic [11:0] addr_pin, // multiplexed address
	input wire logic [3:0] dm_pin, // write mask per byte lane
	input wire logic [31:0] dq_i, // data pins, input side
	output logic [31:0] dq_o, // data pins, output side
	output logic dq_oe, // data pins driven
	input wire logic dqs_i, // data strobe, input side
	output logic dqs_o, // data strobe, output side
	output logic dqs_oe // data strobe driven
);
	localparam int MEM_AW = ddrs_pkg::BANK_W + MEM_ROW_BITS + ddrs_pkg::COL_W;
	localparam int DATA_W = ddrs_pkg::DQ_W + ddrs_pkg::DM_W + 1;

	logic [ddrs_pkg::CTL_W-1:0] ctl_s;
	logic [DATA_W-1:0] data_s;
	logic ck_s, cke_s, cs_n_s, dqs_s;
	logic [2:0] cmd;
	logic [1:0] ba_s;
	logic [11:0] addr_s;
	logic [3:0] dm_s;
	logic [31:0] dq_s;

	// control pins reset high so no false clock edge or command appears
	ddrs_sync #(.W(ddrs_pkg::CTL_W), .RST_VAL({ddrs_pkg::CTL_W{1'b1}})) u_ctl_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d({ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin}),
		.q(ctl_s)
	);
	// data, mask and strobe share one depth so a strobe edge meets its own beat
	ddrs_sync #(.W(DATA_W), .RST_VAL('0)) u_data_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d({dqs_i, dm_pin, dq_i}),
		.q(data_s)
	);

	assign {ck_s, cke_s, cs_n_s, cmd, ba_s, addr_s} = ctl_s;
	assign {dqs_s, dm_s, dq_s} = data_s;

	// state
	logic ck_d_reg, dqs_d_reg;
	logic enable_reg, enable_next;
	logic wb_ack_reg, wb_ack_next;
	logic [31:0] wb_dat_reg, wb_dat_next;
	ddrs_pkg::ddrs_pw_e pw_reg, pw_next;
	logic [11:0] mode_reg, mode_next, ext_mode_reg, ext_mode_next;
	logic mode_wr_reg, mode_wr_next, ext_wr_reg, ext_wr_next;
	logic [3:0][11:0] row_reg, row_next;
	logic [3:0] open_reg, open_next;
	logic [15:0] ref_cnt_reg, ref_cnt_next;
	logic [7:0] dll_cnt_reg, dll_cnt_next;
	logic dll_lock_reg, dll_lock_next;
	ddrs_pkg::ddrs_dp_e dp_reg, dp_next;
	logic [1:0] bank_reg, bank_next;
	logic [MEM_ROW_BITS-1:0] row_lo_reg, row_lo_next;
	logic [7:0] col_base_reg, col_base_next;
	logic ap_reg, ap_next;
	logic intl_reg, intl_next;
	logic [8:0] bl_reg, bl_next;
	logic [8:0] beat_reg, beat_next;
	logic [1:0] lat_reg, lat_next;
	logic [31:0] dq_o_reg, dq_o_next;
	logic dqs_o_reg, dqs_o_next;
	logic oe_reg, oe_next;

	logic ck_rise, ck_fall, ck_run, dqs_edge;
	logic cmd_edge, is_read, is_write, is_term;
	logic burst_end;
	logic mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [31:0] mem_rd;
	logic [7:0] column_address_bits;
	logic [11:0] row_address_bits;
	logic auto_precharge_flag;

	function automatic logic [8:0] burst_beats(input logic [2:0] code);
		unique case (code)
			ddrs_pkg::BL_CODE_2: burst_beats = ddrs_pkg::BEATS_2;
			ddrs_pkg::BL_CODE_4: burst_beats = ddrs_pkg::BEATS_4;
			ddrs_pkg::BL_CODE_8: burst_beats = ddrs_pkg::BEATS_8;
			ddrs_pkg::BL_CODE_FULL: burst_beats = ddrs_pkg::BEATS_FULL;
			default: burst_beats = ddrs_pkg::BEATS_2;
		endcase
	endfunction

	// wrap inside the burst's aligned block; full page wraps the whole row
	function automatic logic [7:0] burst_col(input logic [7:0] base, input logic [8:0] k,
			input logic [8:0] bl, input logic intl);
		logic [7:0] m;
		logic [7:0] kk;
		m = 8'(bl - 9'h001);
		kk = k[7:0];
		if (intl) begin
			burst_col = (base & ~m) | ((base ^ kk) & m);
		end else begin
			burst_col = (base & ~m) | (8'(base + kk) & m);
		end
	endfunction

	// edge finding and command decode
	assign ck_rise = ck_s & ~ck_d_reg;
	assign ck_fall = ~ck_s & ck_d_reg;
	assign ck_run = (pw_reg == ddrs_pkg::PW_ACTIVE);
	assign dqs_edge = dqs_s ^ dqs_d_reg;
	// gated clock while enable low; decoder off while select high
	assign cmd_edge = ck_rise & ck_run & cke_s & ~cs_n_s & enable_reg;
	assign is_read = cmd_edge && (cmd == ddrs_pkg::CMD_READ);
	assign is_write = cmd_edge && (cmd == ddrs_pkg::CMD_WRITE);
	assign is_term = cmd_edge && (cmd == ddrs_pkg::CMD_TERM);
	assign row_address_bits = addr_s;
	assign column_address_bits = addr_s[7:0];
	assign auto_precharge_flag = addr_s[ddrs_pkg::AP_BIT];

	// register bus
	always_comb begin
		enable_next = enable_reg;
		wb_ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
		wb_dat_next = wb_dat_reg;
		if (wb_ack_next) begin
			wb_dat_next = 32'h0000_0000;
			unique case (wb_adr_i)
				ddrs_pkg::OFS_CTRL: wb_dat_next[ddrs_pkg::CTRL_ENABLE_BIT] = enable_reg;
				ddrs_pkg::OFS_STATUS: begin
					wb_dat_next[ddrs_pkg::ST_DLL_LOCK_BIT] = dll_lock_reg;
					wb_dat_next[ddrs_pkg::ST_DLL_WAIT_BIT] = (dll_cnt_reg != 8'h00);
					wb_dat_next[ddrs_pkg::ST_PW_LSB +: 2] = pw_reg;
					wb_dat_next[ddrs_pkg::ST_DP_LSB +: 2] = dp_reg;
					wb_dat_next[ddrs_pkg::ST_OPEN_LSB +: 4] = open_reg;
					wb_dat_next[ddrs_pkg::ST_MODE_WR_BIT] = mode_wr_reg;
					wb_dat_next[ddrs_pkg::ST_EXT_WR_BIT] = ext_wr_reg;
				end
				ddrs_pkg::OFS_MODE: wb_dat_next[11:0] = mode_reg;
				ddrs_pkg::OFS_EXT_MODE: wb_dat_next[11:0] = ext_mode_reg;
				ddrs_pkg::OFS_REFRESH_CNT: wb_dat_next[15:0] = ref_cnt_reg;
				default: wb_dat_next = 32'h0000_0000;
			endcase
			if (wb_we_i && wb_sel_i[0] && (wb_adr_i == ddrs_pkg::OFS_CTRL)) begin
				enable_next = wb_dat_i[ddrs_pkg::CTRL_ENABLE_BIT];
			end
		end
	end

	// power state, banks, mode registers, loop lock, refresh count
	always_comb begin
		pw_next = pw_reg;
		mode_next = mode_reg;
		ext_mode_next = ext_mode_reg;
		mode_wr_next = mode_wr_reg;
		ext_wr_next = ext_wr_reg;
		row_next = row_reg;
		open_next = open_reg;
		ref_cnt_next = ref_cnt_reg;
		dll_cnt_next = dll_cnt_reg;
		dll_lock_next = dll_lock_reg;
		unique case (pw_reg)
			ddrs_pkg::PW_ACTIVE: begin
				if (ck_rise && !cke_s) begin
					if (!cs_n_s && enable_reg && (cmd == ddrs_pkg::CMD_REFRESH)) begin
						pw_next = ddrs_pkg::PW_SELF;
						ref_cnt_next = 16'(ref_cnt_reg + 16'h0001);
					end else begin
						pw_next = ddrs_pkg::PW_PDOWN;
					end
				end
			end
			ddrs_pkg::PW_PDOWN, ddrs_pkg::PW_SELF: begin
				// the exit edge carries no command
				if (ck_rise && cke_s) begin
					pw_next = ddrs_pkg::PW_ACTIVE;
				end
			end
			default: pw_next = ddrs_pkg::PW_ACTIVE;
		endcase
		// lock wait counts only clocks that reach the core
		if (ck_rise && ck_run && cke_s && (dll_cnt_reg != 8'h00)) begin
			dll_cnt_next = dll_cnt_reg - 8'h01;
			if (dll_cnt_reg == 8'h01) begin
				dll_lock_next = 1'b1;
			end
		end
		if (burst_end && ap_reg) begin
			open_next[bank_reg] = 1'b0;
		end
		if (cmd_edge) begin
			unique case (cmd)
				ddrs_pkg::CMD_ACTIVE: begin
					row_next[ba_s] = row_address_bits;
					open_next[ba_s] = 1'b1;
				end
				ddrs_pkg::CMD_PRECHARGE: begin
					if (addr_s[ddrs_pkg::PRE_ALL_BIT]) begin
						open_next = 4'h0;
					end else begin
						open_next[ba_s] = 1'b0;
					end
				end
				ddrs_pkg::CMD_REFRESH: ref_cnt_next = 16'(ref_cnt_reg + 16'h0001);
				ddrs_pkg::CMD_MRS: begin
					if (ba_s[ddrs_pkg::EMR_SEL_BA_BIT]) begin
						ext_mode_next = addr_s;
						ext_wr_next = 1'b1;
					end else begin
						mode_next = addr_s;
						mode_wr_next = 1'b1;
						if (addr_s[ddrs_pkg::MR_DLL_RST_BIT]) begin
							dll_cnt_next = ddrs_pkg::DLL_LOCK_CYCLES;
							dll_lock_next = 1'b0;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// data path: read latency, strobe-timed beats, masked writes
	always_comb begin
		dp_next = dp_reg;
		bank_next = bank_reg;
		row_lo_next = row_lo_reg;
		col_base_next = col_base_reg;
		ap_next = ap_reg;
		intl_next = intl_reg;
		bl_next = bl_reg;
		beat_next = beat_reg;
		lat_next = lat_reg;
		dq_o_next = dq_o_reg;
		dqs_o_next = dqs_o_reg;
		oe_next = oe_reg;
		burst_end = 1'b0;
		mem_we = 1'b0;
		unique case (dp_reg)
			ddrs_pkg::DP_IDLE: begin
			end
			ddrs_pkg::DP_WRITE: begin
				if (dqs_edge) begin
					mem_we = 1'b1;
					beat_next = 9'(beat_reg + 9'h001);
					if (beat_reg == 9'(bl_reg - 9'h001)) begin
						dp_next = ddrs_pkg::DP_IDLE;
						burst_end = 1'b1;
					end
				end
			end
			ddrs_pkg::DP_RD_WAIT: begin
				if (ck_rise && ck_run) begin
					if (lat_reg == 2'h1) begin
						dq_o_next = mem_rd;
						dqs_o_next = 1'b1;
						oe_next = 1'b1;
						beat_next = 9'(beat_reg + 9'h001);
						dp_next = ddrs_pkg::DP_READ;
					end else begin
						lat_next = lat_reg - 2'h1;
					end
				end
			end
			ddrs_pkg::DP_READ: begin
				if ((ck_rise || ck_fall) && ck_run) begin
					if (beat_reg == bl_reg) begin
						oe_next = 1'b0;
						dqs_o_next = 1'b0;
						dp_next = ddrs_pkg::DP_IDLE;
						burst_end = 1'b1;
					end else begin
						// strobe edge-aligned with the clock
						dq_o_next = mem_rd;
						dqs_o_next = ck_rise;
						beat_next = 9'(beat_reg + 9'h001);
					end
				end
			end
		endcase
		if (is_term && ((dp_reg == ddrs_pkg::DP_READ) || (dp_reg == ddrs_pkg::DP_RD_WAIT))) begin
			oe_next = 1'b0;
			dqs_o_next = 1'b0;
			dp_next = ddrs_pkg::DP_IDLE;
			burst_end = 1'b1;
		end
		// a read during a write burst is refused; write always completes
		if ((dp_next == ddrs_pkg::DP_IDLE) && (is_read || is_write)) begin
			bank_next = ba_s;
			row_lo_next = row_reg[ba_s][MEM_ROW_BITS-1:0];
			col_base_next = column_address_bits;
			ap_next = auto_precharge_flag;
			bl_next = burst_beats(mode_reg[ddrs_pkg::MR_BL_LSB +: 3]);
			intl_next = mode_reg[ddrs_pkg::MR_BT_BIT];
			beat_next = 9'h000;
			lat_next = ddrs_pkg::READ_LATENCY;
			dp_next = is_write ? ddrs_pkg::DP_WRITE : ddrs_pkg::DP_RD_WAIT;
		end
	end

	// beat address follows burst order from the latched start column
	assign mem_addr = {bank_reg, row_lo_reg, burst_col(col_base_reg, beat_reg, bl_reg, intl_reg)};

	ddrs_mem #(.AW(MEM_AW), .DW(ddrs_pkg::DQ_W), .BW(ddrs_pkg::DM_W)) u_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_we),
		.wr_addr(mem_addr),
		.wr_data(dq_s),
		.wr_be(~dm_s),
		.rd_addr(mem_addr),
		.rd_data(mem_rd)
	);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ck_d_reg <= 1'b1;
			dqs_d_reg <= 1'b0;
			enable_reg <= ddrs_pkg::CTRL_ENABLE_RESET;
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h0000_0000;
			pw_reg <= ddrs_pkg::PW_ACTIVE;
			mode_reg <= 12'h000;
			ext_mode_reg <= 12'h000;
			mode_wr_reg <= 1'b0;
			ext_wr_reg <= 1'b0;
			row_reg <= '0;
			open_reg <= 4'h0;
			ref_cnt_reg <= 16'h0000;
			dll_cnt_reg <= 8'h00;
			dll_lock_reg <= 1'b0;
			dp_reg <= ddrs_pkg::DP_IDLE;
			bank_reg <= 2'h0;
			row_lo_reg <= '0;
			col_base_reg <= 8'h00;
			ap_reg <= 1'b0;
			intl_reg <= 1'b0;
			bl_reg <= ddrs_pkg::BEATS_2;
			beat_reg <= 9'h000;
			lat_reg <= 2'h0;
			dq_o_reg <= 32'h0000_0000;
			dqs_o_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			ck_d_reg <= ck_s;
			dqs_d_reg <= dqs_s;
			enable_reg <= enable_next;
			wb_ack_reg <= wb_ack_next;
			wb_dat_reg <= wb_dat_next;
			pw_reg <= pw_next;
			mode_reg <= mode_next;
			ext_mode_reg <= ext_mode_next;
			mode_wr_reg <= mode_wr_next;
			ext_wr_reg <= ext_wr_next;
			row_reg <= row_next;
			open_reg <= open_next;
			ref_cnt_reg <= ref_cnt_next;
			dll_cnt_reg <= dll_cnt_next;
			dll_lock_reg <= dll_lock_next;
			dp_reg <= dp_next;
			bank_reg <= bank_next;
			row_lo_reg <= row_lo_next;
			col_base_reg <= col_base_next;
			ap_reg <= ap_next;
			intl_reg <= intl_next;
			bl_reg <= bl_next;
			beat_reg <= beat_next;
			lat_reg <= lat_next;
			dq_o_reg <= dq_o_next;
			dqs_o_reg <= dqs_o_next;
			oe_reg <= oe_next;
		end
	end

	assign wb_ack_o = wb_ack_reg;
	assign wb_dat_o = wb_dat_reg;
	assign dq_o = dq_o_reg;
	assign dq_oe = oe_reg;
	assign dqs_o = dqs_o_reg;
	assign dqs_oe = oe_reg;
endmodule
`default_nettype wire

//--- tb/ddrs_device_monitor.sv
/* checker for ddrs_device: bus handshake and read strobe timing.
 * assumes it is bound to ddrs_device and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ddrs_device_monitor #(
	parameter int MEM_ROW_BITS = 2
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // bus write
	input wire logic [7:0] wb_adr_i, // bus address
	input wire logic [31:0] wb_dat_o, // bus read data
	input wire logic wb_ack_o, // bus acknowledge
	input wire logic ck_pin, // memory clock
	input wire logic cke_pin, // clock enable
	input wire logic cs_n_pin, // chip select
	input wire logic ras_n_pin, // row strobe
	input wire logic cas_n_pin, // column strobe
	input wire logic we_n_pin, // write enable
	input wire logic dq_oe, // data driven
	input wire logic dqs_o, // strobe out
	input wire logic dqs_oe // strobe driven
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	logic ck_q_reg, ck_q_next, ck_rise;
	logic [2:0] rises_reg, rises_next;
	assign ck_rise = ck_pin && !ck_q_reg;
	// rises since the last selected read; saturates so stale reads never match
	always_comb begin
		ck_q_next = ck_pin;
		rises_next = rises_reg;
		if (ck_rise && cke_pin && !cs_n_pin
			&& {ras_n_pin, cas_n_pin, we_n_pin} == ddrs_pkg::CMD_READ) begin
			rises_next = 3'h0;
		end else if (ck_rise && rises_reg != 3'h7) begin
			rises_next = rises_reg + 3'h1;
		end
		if (!rst_n) begin
			rises_next = 3'h7;
		end
	end
	always_ff @(posedge clk_sys) begin
		ck_q_reg <= ck_q_next;
		rises_reg <= rises_next;
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_first_beat;
		dqs_o [*4] ##1 (!dqs_o && dq_oe);
	endsequence
	property p_rd_lat;
		$rose(dq_oe) |-> rises_reg == 3'h3;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data not three clocks after read");
	property p_first_beat;
		$rose(dq_oe) |-> s_first_beat;
	endproperty
	a_first_beat: assert property (p_first_beat) else $error("read beats not on both edges");
	property p_oe_pair;
		dq_oe == dqs_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("data and strobe enables differ");
	property p_oe_end;
		$fell(dq_oe) |-> !$past(dqs_o);
	endproperty
	a_oe_end: assert property (p_oe_end) else $error("burst ended on a rise beat");
	property p_ack_resp;
		s_req |=> wb_ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("bus request not acknowledged");
	property p_ack_drop;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("acknowledge longer than one cycle");
	property p_ack_cause;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
	property p_unmapped;
		wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind ddrs_device ddrs_device_monitor #(.MEM_ROW_BITS(MEM_ROW_BITS)) mon_u (.*);
`default_nettype wire

//--- tb/ddrs_ctrl_model.sv
/* memory controller model: free clock, commands, write bursts, power-up.
 * assumes clk_sys of 20 ns; the memory clock runs free at 160 ns. */
`timescale 1ns/1ps
`default_nettype none
module ddrs_ctrl_model (
	input wire logic clk_sys, // system clock
	output logic ck_pin, // memory clock
	output logic cke_pin, // clock enable
	output logic cs_n_pin, // chip select
	output logic ras_n_pin, // row strobe
	output logic cas_n_pin, // column strobe
	output logic we_n_pin, // write enable
	output logic [1:0] ba_pin, // bank
	output logic [11:0] addr_pin, // address
	output logic [3:0] dm_pin, // write mask
	output logic [31:0] m_dq, // data, inverted when released
	output logic m_dqs // strobe, held low when idle
);
	logic [31:0] wd [8];
	logic [3:0] wm [8];
	initial begin
		ck_pin = 1'b0;
		#13;
		forever #80 ck_pin = ~ck_pin; // fixed rate, no re-lock
	end
	initial begin
		cke_pin = 1'b0;
		cs_n_pin = 1'b1;
		{ras_n_pin, cas_n_pin, we_n_pin} = 3'h7;
		ba_pin = 2'h0;
		addr_pin = 12'h000;
		dm_pin = 4'h0;
		m_dq = 32'h0;
		m_dqs = 1'b0;
	end
	// command held a whole clock period around its rising edge
	task automatic cmd(input logic sel_n, input logic [2:0] c, input logic [1:0] b,
		input logic [11:0] a);
		@(negedge ck_pin);
		@(posedge clk_sys);
		cs_n_pin <= sel_n;
		{ras_n_pin, cas_n_pin, we_n_pin} <= c;
		ba_pin <= b;
		addr_pin <= a;
		@(negedge ck_pin);
		@(posedge clk_sys);
		cs_n_pin <= 1'b0;
		{ras_n_pin, cas_n_pin, we_n_pin} <= 3'h7;
		ba_pin <= ~b;
		addr_pin <= ~a;
	endtask
	task automatic set_cke(input logic v);
		@(negedge ck_pin);
		@(posedge clk_sys);
		cke_pin <= v;
	endtask
	// data centred on each strobe edge, three cycles either side
	task automatic write_beats(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			m_dq <= wd[i];
			dm_pin <= wm[i];
			repeat (3) @(posedge clk_sys);
			m_dqs <= ~m_dqs;
			repeat (2) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		m_dq <= ~m_dq;
		dm_pin <= ~dm_pin;
	endtask
	task automatic init_seq(input logic [11:0] mode);
		repeat (1250) @(posedge ck_pin);
		set_cke(1'b1);
		cmd(1'b0, 3'h7, 2'h0, 12'h000);
		cmd(1'b0, ddrs_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
		cmd(1'b0, ddrs_pkg::CMD_MRS, 2'h1, 12'h000);
		cmd(1'b0, ddrs_pkg::CMD_MRS, 2'h0, mode | 12'h100);
		cmd(1'b0, ddrs_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
		repeat (2) cmd(1'b0, ddrs_pkg::CMD_REFRESH, 2'h0, 12'h000);
		cmd(1'b0, ddrs_pkg::CMD_MRS, 2'h0, mode);
		repeat (200) @(posedge ck_pin);
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
/* self-checking bench for ddrs_device with the controller model.
 * assumes the monitor is bound in; clk_sys 50 MHz, memory clock 160 ns. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, dq_o, m_dq, dq_bus;
	logic wb_ack_o, ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
	logic [1:0] ba_pin;
	logic [11:0] addr_pin, mode;
	logic [3:0] dm_pin;
	logic m_dqs, dqs_o, dq_oe, dqs_oe, dqs_bus, prev_oe, prev_dqs, il;
	logic [31:0] rd, seed, d1 [8], exp_m [8];
	logic [31:0] beats_q [$];
	logic [2:0] codes [4] = '{ddrs_pkg::BL_CODE_2, ddrs_pkg::BL_CODE_4,
		ddrs_pkg::BL_CODE_8, ddrs_pkg::BL_CODE_4};
	int error_cnt = 0;
	int comparisons = 0;
	int n, rs;
	always #10 clk_sys = ~clk_sys;
	// no pull on data or strobe: whoever enables drives the wire
	assign dq_bus = dq_oe ? dq_o : m_dq;
	assign dqs_bus = dqs_oe ? dqs_o : m_dqs;
	ddrs_ctrl_model ctl_u (.*);
	ddrs_device dut_u (.*, .dq_i(dq_bus), .dqs_i(dqs_bus));
	always @(negedge clk_sys) begin
		if (dq_oe === 1'b1 && (prev_oe !== 1'b1 || dqs_o !== prev_dqs)) begin
			beats_q.push_back(dq_o);
		end
		prev_oe = dq_oe;
		prev_dqs = dqs_o;
	end
	function automatic logic [31:0] next_rand(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] m);
		for (int k = 0; k < 4; k++) begin
			if (!m[k]) old[8*k +: 8] = nw[8*k +: 8];
		end
		return old;
	endfunction
	function automatic int col_of(input int s, input int i, input int bl, input logic ilv);
		return ilv ? (s ^ i) : ((s & ~(bl - 1)) | ((s + i) & (bl - 1)));
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int t;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		if (wb_ack_o !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// refused reads wait past the latency window and expect no beat
	task automatic read_burst(input logic sel_n, input logic [1:0] b, input logic [11:0] a,
		input int cnt);
		int t;
		beats_q.delete();
		ctl_u.cmd(sel_n, ddrs_pkg::CMD_READ, b, a);
		t = 0;
		if (cnt == 0) repeat (48) @(posedge clk_sys);
		while (cnt > 0 && (beats_q.size() < cnt || dq_oe !== 1'b0) && t < 200) begin
			@(posedge clk_sys);
			t++;
		end
		if (t >= 200) begin
			error_cnt++;
			report_and_stop();
		end
		chk("beat count", 32'(beats_q.size()), 32'(cnt));
	endtask
	initial begin
		seed = 32'h6c70;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		wb(1'b0, ddrs_pkg::OFS_CTRL, 32'h0, rd);
		chk("ctrl", rd, 32'h1);
		wb(1'b0, ddrs_pkg::OFS_MODE, 32'h0, rd);
		chk("mode", rd, 32'h0);
		ctl_u.init_seq(12'h032);
		wb(1'b0, ddrs_pkg::OFS_STATUS, 32'h0, rd);
		chk("status", rd & 32'h300f, 32'h3001);
		wb(1'b0, ddrs_pkg::OFS_REFRESH_CNT, 32'h0, rd);
		chk("refresh count", rd, 32'h2);
		wb(1'b0, ddrs_pkg::OFS_EXT_MODE, 32'h0, rd);
		chk("ext mode", rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		for (int t = 0; t < 4; t++) begin
			n = (codes[t] == ddrs_pkg::BL_CODE_2) ? 2 : (codes[t] == ddrs_pkg::BL_CODE_4) ? 4 : 8;
			il = (t == 3);
			rs = il ? 1 : 0;
			mode = {5'h00, 3'h3, il, codes[t]}; // no full page drawn
			ctl_u.cmd(1'b0, ddrs_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
			ctl_u.cmd(1'b0, ddrs_pkg::CMD_MRS, 2'h0, mode);
			wb(1'b0, ddrs_pkg::OFS_MODE, 32'h0, rd);
			chk("mode", rd, {20'h0, mode});
			ctl_u.cmd(1'b0, ddrs_pkg::CMD_ACTIVE, 2'(t), 12'(t) | 12'h800);
			wb(1'b0, ddrs_pkg::OFS_STATUS, 32'h0, rd);
			chk("open bank", rd & 32'h0f00, 32'h100 << t);
			for (int i = 0; i < n; i++) begin
				seed = next_rand(seed);
				d1[i] = seed;
				ctl_u.wd[i] = seed;
				ctl_u.wm[i] = 4'h0;
			end
			ctl_u.cmd(1'b0, ddrs_pkg::CMD_WRITE, 2'(t), 12'h000);
			ctl_u.write_beats(n);
			for (int i = 0; i < n; i++) begin
				seed = next_rand(seed);
				ctl_u.wd[i] = seed;
				ctl_u.wm[i] = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : seed[7:4];
				exp_m[i] = merge(d1[i], seed, ctl_u.wm[i]);
			end
			ctl_u.cmd(1'b0, ddrs_pkg::CMD_WRITE, 2'(t), 12'h000);
			ctl_u.write_beats(n);
			read_burst(1'b0, 2'(t), 12'h100 | 12'(rs), n);
			for (int i = 0; i < n; i++) begin
				chk("read beat", beats_q[i], exp_m[col_of(rs, i, n, il)]);
			end
			wb(1'b0, ddrs_pkg::OFS_STATUS, 32'h0, rd);
			chk("auto precharge", rd & 32'h0f00, 32'h0);
		end
		ctl_u.cmd(1'b0, ddrs_pkg::CMD_ACTIVE, 2'h0, 12'h000);
		read_burst(1'b1, 2'h0, 12'h000, 0);
		ctl_u.set_cke(1'b0);
		repeat (16) @(posedge clk_sys);
		wb(1'b0, ddrs_pkg::OFS_STATUS, 32'h0, rd);
		chk("power down", rd & 32'hc, 32'h4);
		read_burst(1'b0, 2'h0, 12'h000, 0);
		ctl_u.set_cke(1'b1);
		ctl_u.cmd(1'b0, 3'h7, 2'h0, 12'h000);
		wb(1'b0, ddrs_pkg::OFS_STATUS, 32'h0, rd);
		chk("power up", rd & 32'hc, 32'h0);
		wb(1'b1, ddrs_pkg::OFS_CTRL, 32'h0, rd);
		read_burst(1'b0, 2'h0, 12'h000, 0);
		wb(1'b1, ddrs_pkg::OFS_CTRL, 32'h1, rd);
		read_burst(1'b0, 2'h0, 12'h000, 4);
		report_and_stop();
	end
endmodule
`default_nettype wire
